// ==== hdl/mfp_pkg.sv ====
// package for the motor driver fault-protection host controller
// assumes a 20 MHz clock and a synchronous, active-high reset
package mfp_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int HOLD_WORST_MS = 5;
   localparam int RESTART_MS = 2000;
   localparam int DEAD_NS = 1500;
   localparam int CMD_CYC_PER_MS = CLK_HZ / 1000;
   localparam int HOLD_CYC = HOLD_WORST_MS * CMD_CYC_PER_MS;
   localparam int RESTART_CYC = RESTART_MS * CMD_CYC_PER_MS;
   localparam int DEAD_CYC = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CNT_W = 27;
   // register word addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CMD = 4'h1;
   localparam logic [3:0] ADDR_STAT = 4'h2;
   localparam logic [3:0] ADDR_IRQ_ST = 4'h3;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
   // bit positions
   localparam int CTRL_RUN = 0;
   localparam int CTRL_OVERHEAT = 1;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_RESTART_OK = 1;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   typedef enum logic [1:0] {MFP_IDLE, MFP_RUN, MFP_STOP_WAIT} mfp_state_e;
   typedef struct packed
   {
      logic [2:0] high;
      logic [2:0] low;
   } mfp_gate_s;
endpackage

// ==== hdl/mfp_host.sv ====
// host-side controller that commands the three-phase gate driver and reacts to its fault output
// assumes fault_out_n is already synchronous to clk; software uses the plain register port
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Contract
// R1 - device pulls fault output low on supply lockout, overcurrent or thermal trip
// R2 - device forces all low-side gates off while fault output is low
// R3 - device holds fault low about 10 ms after an overcurrent trip
// R4 - device keeps fault output high when no protection is active
// R5 - controller drives all six commands low well within the 5 ms hold
// R6 - controller treats fault as interrupt and stops the motor at once
// R7 - controller waits at least 2 seconds after a fault before restarting; a fault seen in MFP_IDLE starts no wait
// R8 - device forces one phase high gate low at bootstrap lockout
// R9 - device releases bootstrap lockout with hysteresis
// R10 - device re-arms high gate only on next rising command edge
// R11 - device does not report bootstrap lockout on fault output
// R12 - device filters bootstrap undervoltage pulses shorter than about 3 us
// R13 - controller turns off all commands on abnormal sensed temperature
// R14 - device latches high gate on command rising edge, clears on falling
// R15 - controller inserts at least 1.5 us dead time between a phase's commands
// R16 - device gates everything off and signals fault under logic supply lockout
// R17 - device trips overcurrent after blanking and turns low gates off shortly after
// R18 - comparator results are digital inputs; filters and holds are counters
module mfp_host
   import mfp_pkg::*;
#(
   parameter int RESTART_CYCLES = RESTART_CYC
)
(
   input wire logic clk, // 20 MHz clock
   input wire logic reset, // synchronous, active high
   input wire logic [3:0] addr, // register word address
   input wire logic [31:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [31:0] rdata, // read data, cycle after rd
   output logic irq, // level interrupt
   input wire logic fault_out_n, // device fault output, low = fault
   output logic [2:0] high_side_cmd, // high-side commands
   output logic [2:0] low_side_cmd // low-side commands
);
   mfp_state_e state_r, state_nxt;
   mfp_gate_s want_r, want_nxt;
   mfp_gate_s cmd_r, cmd_nxt;
   logic [2:0][4:0] dcnt_r, dcnt_nxt;
   logic [CNT_W-1:0] wait_r, wait_nxt;
   logic [1:0] ctrl_r, ctrl_nxt;
   logic [1:0] ist_r, ist_nxt;
   logic [1:0] imask_r, imask_nxt;
   logic [31:0] rdata_nxt;
   logic irq_nxt;
   logic fault_seen;
   logic [1:0] ev;

   function automatic logic [31:0] zext2(input logic [1:0] v);
      zext2 = {30'h0, v};
   endfunction

   assign fault_seen = ~fault_out_n;

   always_comb
   begin
      state_nxt = state_r;
      wait_nxt = wait_r;
      ev = 2'h0;
      ctrl_nxt = ctrl_r;
      want_nxt = want_r;
      imask_nxt = imask_r;
      if (wr && addr == ADDR_CTRL)
         ctrl_nxt = wdata[1:0];
      if (wr && addr == ADDR_CMD)
         want_nxt = wdata[5:0];
      if (wr && addr == ADDR_IRQ_MASK)
         imask_nxt = wdata[1:0];
      case (state_r)
         MFP_IDLE:
         begin
            if (ctrl_r[CTRL_RUN] && !ctrl_r[CTRL_OVERHEAT] && !fault_seen)
               state_nxt = MFP_RUN;
         end
         MFP_RUN:
         begin
            // stop on fault or overheat in the same edge the level is seen
            if (fault_seen || ctrl_r[CTRL_OVERHEAT] || !ctrl_r[CTRL_RUN]) // see R6 see R13
            begin
               state_nxt = fault_seen ? MFP_STOP_WAIT : MFP_IDLE;
               wait_nxt = '0;
               if (fault_seen)
                  ev[IRQ_FAULT] = 1'b1; // see R6
            end
         end
         MFP_STOP_WAIT:
         begin
            // the wait restarts while fault is still low
            if (fault_seen)
               wait_nxt = '0;
            else if (wait_r >= CNT_W'(RESTART_CYCLES - 1)) // see R7
            begin
               state_nxt = MFP_IDLE;
               ev[IRQ_RESTART_OK] = 1'b1;
            end
            else
               wait_nxt = wait_r + 1'b1;
         end
         default: state_nxt = MFP_IDLE;
      endcase
      if (fault_seen && state_r == MFP_IDLE)
         ev[IRQ_FAULT] = 1'b1;
      // set wins over the write-one clear
      ist_nxt = ist_r;
      if (wr && addr == ADDR_IRQ_ST)
         ist_nxt = ist_r & ~wdata[1:0];
      ist_nxt = ist_nxt | ev;
      irq_nxt = |(ist_nxt & imask_nxt);
      rdata_nxt = RD_UNMAPPED;
      if (rd)
      begin
         case (addr)
            ADDR_CTRL: rdata_nxt = zext2(ctrl_r);
            ADDR_CMD: rdata_nxt = {26'h0, want_r};
            ADDR_STAT: rdata_nxt = {20'h0, cmd_r, fault_seen, 3'h0, state_r};
            ADDR_IRQ_ST: rdata_nxt = zext2(ist_r);
            ADDR_IRQ_MASK: rdata_nxt = zext2(imask_r);
            default: rdata_nxt = RD_UNMAPPED;
         endcase
      end
   end

   // dead-time and command path
   always_comb
   begin
      cmd_nxt = '0;
      dcnt_nxt = dcnt_r;
      for (int p = 0; p < 3; p++)
      begin
         // a side may switch on only after the other side has been off DEAD_CYC cycles
         if (cmd_r.high[p] || cmd_r.low[p])
            dcnt_nxt[p] = '0;
         else if (dcnt_r[p] != 5'(DEAD_CYC))
            dcnt_nxt[p] = dcnt_r[p] + 1'b1;
         if (state_r == MFP_RUN && !fault_seen && !ctrl_r[CTRL_OVERHEAT]) // see R5 see R13
         begin
            if (want_r.high[p] && !want_r.low[p])
               cmd_nxt.high[p] = cmd_r.high[p] || (dcnt_r[p] == 5'(DEAD_CYC) && !cmd_r.low[p]); // see R15
            else if (want_r.low[p] && !want_r.high[p])
               cmd_nxt.low[p] = cmd_r.low[p] || (dcnt_r[p] == 5'(DEAD_CYC) && !cmd_r.high[p]); // see R15
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_r <= MFP_IDLE;
         wait_r <= '0;
         ctrl_r <= 2'h0;
         want_r <= '0;
         cmd_r <= '0;
         dcnt_r <= '0;
         ist_r <= 2'h0;
         imask_r <= 2'h0;
         rdata <= 32'h0;
         irq <= 1'b0;
         high_side_cmd <= 3'h0;
         low_side_cmd <= 3'h0;
      end
      else
      begin
         state_r <= state_nxt;
         wait_r <= wait_nxt;
         ctrl_r <= ctrl_nxt;
         want_r <= want_nxt;
         cmd_r <= cmd_nxt;
         dcnt_r <= dcnt_nxt;
         ist_r <= ist_nxt;
         imask_r <= imask_nxt;
         rdata <= rdata_nxt;
         irq <= irq_nxt;
         high_side_cmd <= cmd_nxt.high;
         low_side_cmd <= cmd_nxt.low;
      end
   end

   // checker state, kept apart from the command path so the checks do not reuse its counters
   logic [2:0][4:0] gap_r, gap_nxt;
   logic [2:0] on_prev_r, on_prev_nxt;
   logic gap_ok;
   logic [CNT_W-1:0] stop_age_r, stop_age_nxt;

   always_comb
   begin
      gap_ok = 1'b1;
      on_prev_nxt = high_side_cmd | low_side_cmd;
      gap_nxt = gap_r;
      for (int p = 0; p < 3; p++)
      begin
         if (on_prev_nxt[p])
            gap_nxt[p] = '0;
         else if (gap_r[p] != 5'(DEAD_CYC))
            gap_nxt[p] = gap_r[p] + 1'b1;
         // any side switching on must follow a full all-off gap
         if (on_prev_nxt[p] && !on_prev_r[p] && gap_r[p] != 5'(DEAD_CYC))
            gap_ok = 1'b0; // see R15
      end
      // age counts from the stop itself, not from the fault release
      stop_age_nxt = stop_age_r;
      if (state_r == MFP_RUN && state_nxt == MFP_STOP_WAIT)
         stop_age_nxt = '0;
      else if (stop_age_r != CNT_W'(RESTART_CYCLES))
         stop_age_nxt = stop_age_r + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         gap_r <= '0;
         on_prev_r <= 3'h0;
         stop_age_r <= '0;
      end
      else
      begin
         gap_r <= gap_nxt;
         on_prev_r <= on_prev_nxt;
         stop_age_r <= stop_age_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   fault_cmds_off_a: assert property (fault_seen |=> (high_side_cmd == 3'h0 && low_side_cmd == 3'h0)) // see R5
      else $error("commands not off one cycle after fault");
   fault_irq_set_a: assert property (fault_seen && state_r == MFP_RUN |=> ist_r[IRQ_FAULT]) // see R6
      else $error("fault event not latched");
   overheat_off_a: assert property (ctrl_r[CTRL_OVERHEAT] |=> high_side_cmd == 3'h0 && low_side_cmd == 3'h0) // see R13
      else $error("commands on while overheat flagged");
   no_shoot_a: assert property ((high_side_cmd & low_side_cmd) == 3'h0) // see R15
      else $error("both sides on in one phase");
   dead_gap_a: assert property ($fell(low_side_cmd[0]) |-> ##1 !high_side_cmd[0] [*8]) // see R15
      else $error("dead time too short on phase 0");
   restart_hold_a: assert property ($rose(state_r == MFP_STOP_WAIT) |=> state_r != MFP_RUN [*8]) // see R7
      else $error("restarted too soon after fault");
   wait_full_a: assert property (state_r == MFP_STOP_WAIT && state_nxt == MFP_IDLE |-> stop_age_r >= CNT_W'(RESTART_CYCLES - 1)) // see R7
      else $error("restart wait not complete");
   irq_level_a: assert property (irq == $past(|(ist_nxt & imask_nxt))) // see R6
      else $error("interrupt level mismatch");
   dead_count_a: assert property (gap_ok) // see R15
      else $error("side switched on before the full dead gap");

   fault_stop_c: cover property (state_r == MFP_RUN ##1 state_r == MFP_STOP_WAIT);
   restart_c: cover property (state_r == MFP_STOP_WAIT ##1 state_r == MFP_IDLE);
   high_on_c: cover property ($rose(high_side_cmd[1]));
   idle_fault_c: cover property (fault_seen && state_r == MFP_IDLE);
endmodule

// ==== sim/mfp_dev_model.sv ====
// behavioural gate-driver device: fault output with hold, low-side gating
// assumes trip inputs are digital comparator results driven by the bench
`timescale 1ns/1ps
module mfp_dev_model
#(
   parameter int HOLD = 20, // fault hold, in clocks
   parameter int FILT = 60 // bootstrap undervoltage filter, in clocks
)
(
   input wire logic clk, // host clock
   input wire logic overcurrent_trip, // overcurrent comparator, after blanking
   input wire logic thermal_trip, // thermal comparator
   input wire logic logic_supply_lockout, // logic supply low
   input wire logic [2:0] bootstrap_supply_lockout, // per-phase bootstrap low, comparator with hysteresis
   input wire logic [2:0] high_side_cmd, // high-side commands
   input wire logic [2:0] low_side_cmd, // low-side commands
   output logic fault_out_n, // fault, active low
   output logic [2:0] high_gate_drive, // high-side gates
   output logic [2:0] low_gate_drive // low-side gates
);
   int hold_r = 0;
   int filt_r [3] = '{0, 0, 0};
   logic [2:0] locked_r = 3'h0;
   logic [2:0] latch_r = 3'h0;
   logic [2:0] cmd_prev_r = 3'h0;
   // hold is counted in clocks, scaled down to keep runs short
   always @(posedge clk)
   begin
      if (overcurrent_trip)
         hold_r <= HOLD;
      else if (hold_r > 0)
         hold_r <= hold_r - 1;
      cmd_prev_r <= high_side_cmd;
      for (int p = 0; p < 3; p++)
      begin
         // short dips are treated as noise
         if (!bootstrap_supply_lockout[p])
            filt_r[p] <= 0;
         else if (filt_r[p] < FILT)
            filt_r[p] <= filt_r[p] + 1;
         if (bootstrap_supply_lockout[p] && filt_r[p] == FILT - 1)
            locked_r[p] <= 1'b1;
         else if (!bootstrap_supply_lockout[p])
            locked_r[p] <= 1'b0;
         // a command already high at release does not re-arm the gate
         if (locked_r[p])
            latch_r[p] <= 1'b0;
         else if (high_side_cmd[p] && !cmd_prev_r[p])
            latch_r[p] <= 1'b1;
         else if (!high_side_cmd[p] && cmd_prev_r[p])
            latch_r[p] <= 1'b0;
      end
   end
   // bootstrap lockout never reaches this pin
   assign fault_out_n = !(overcurrent_trip || thermal_trip || logic_supply_lockout || hold_r > 0);
   assign high_gate_drive = latch_r & ~locked_r & {3{!logic_supply_lockout}};
   assign low_gate_drive = fault_out_n ? low_side_cmd : 3'h0;
endmodule

// ==== sim/mfp_host_test.sv ====
// self-checking bench for the fault-protection host controller
// assumes the device model above sits on the fault and command pins
`timescale 1ns/1ps
module mfp_host_test;
   import mfp_pkg::*;
   localparam int RST = 50;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ov = 1'b0;
   logic th = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic irq, fault_out_n;
   logic [2:0] high_side_cmd, low_side_cmd;
   int n_fail = 0;
   int checked = 0;
   mfp_host #(.RESTART_CYCLES(RST)) DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .fault_out_n(fault_out_n), .high_side_cmd(high_side_cmd),
      .low_side_cmd(low_side_cmd));
   mfp_dev_model dev (.clk(clk), .overcurrent_trip(ov), .thermal_trip(th), .logic_supply_lockout(1'b0),
      .bootstrap_supply_lockout(3'h0), .high_side_cmd(high_side_cmd), .low_side_cmd(low_side_cmd),
      .fault_out_n(fault_out_n), .high_gate_drive(), .low_gate_drive());
   initial forever #25 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic cmds(input logic [31:0] exp);
      #1 chk(32'({high_side_cmd, low_side_cmd}), exp);
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      n_fail++;
      complete_run();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rchk(ADDR_STAT, 32'h0);
      rchk(ADDR_IRQ_MASK, 32'h0);
      rchk(4'hf, RD_UNMAPPED);
      wreg(ADDR_IRQ_MASK, 32'h2);
      wreg(ADDR_CTRL, 32'h1);
      wreg(ADDR_CMD, 32'h8);
      repeat (40) @(posedge clk);
      rchk(ADDR_STAT, 32'h201);
      // side swap must pass through an all-off gap
      wreg(ADDR_CMD, 32'h1);
      repeat (10) @(posedge clk);
      cmds(32'h0);
      repeat (40) @(posedge clk);
      cmds(32'h1);
      @(posedge clk);
      ov <= 1'b1;
      @(posedge clk);
      ov <= 1'b0;
      repeat (2) @(posedge clk);
      cmds(32'h0);
      chk(32'(irq), 32'h0);
      rchk(ADDR_STAT, 32'h22);
      rchk(ADDR_IRQ_ST, 32'h1);
      for (int i = 0; i < 100 && fault_out_n !== 1'b1; i++)
         @(posedge clk);
      repeat (40) @(posedge clk);
      cmds(32'h0);
      rchk(ADDR_IRQ_ST, 32'h1);
      repeat (20) @(posedge clk);
      chk(32'(irq), 32'h1);
      rchk(ADDR_IRQ_ST, 32'h3);
      wreg(ADDR_IRQ_ST, 32'h3);
      rchk(ADDR_IRQ_ST, 32'h0);
      cmds(32'h1);
      wreg(ADDR_CTRL, 32'h3);
      repeat (2) @(posedge clk);
      cmds(32'h0);
      chk(32'(irq), 32'h0);
      // a thermal fault while stopped still raises the fault event
      @(posedge clk);
      th <= 1'b1;
      repeat (3) @(posedge clk);
      th <= 1'b0;
      rchk(ADDR_IRQ_ST, 32'h1);
      rchk(ADDR_STAT, 32'h0);
      complete_run();
   end
endmodule
